// *** common/tec_pkg.sv ***
// constants for the timer / event counter and tone generator block
package tec_pkg;
	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_COUNT_CTRL = 8'h00;
	localparam logic [7:0] OFS_VALUE_LO   = 8'h04;
	localparam logic [7:0] OFS_VALUE_HI   = 8'h08;
	localparam logic [7:0] OFS_TONE_RUN   = 8'h0C;
	localparam logic [7:0] OFS_EVENT_CFG  = 8'h10;
	localparam logic [7:0] OFS_IRQ_REQ    = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
	localparam logic [7:0] OFS_TONE_PORT  = 8'h1C;
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_AUTO_BIT   = 3;
	localparam int RUN_EN_BIT      = 3;
	localparam int TONE_EN_BIT     = 2;
	localparam int EVT_MODE_BIT    = 0;
	localparam int EVT_BYPASS_BIT  = 1;
	localparam int EVT_RISING_BIT  = 2;
	localparam int EVT_DEBLONG_BIT = 3;
	localparam int IRQ_ZERO_BIT    = 2;
	localparam int PORT_DIR_BIT    = 0;
	localparam int PORT_DATA_BIT   = 1;
	// ****************************************************************
	// reset values and encodings
	// ****************************************************************
	localparam logic [3:0] NIBBLE_RST = 4'h0;
	localparam logic [2:0] SRC_OFF    = 3'h0;
	localparam logic [2:0] SRC_EVENT  = 3'h7;
	localparam logic [1:0] TONE_OFF   = 2'h0;
	localparam logic [1:0] TONE_ONE   = 2'h1;
	localparam logic [1:0] TONE_TWO   = 2'h2;
	localparam logic [1:0] TONE_THREE = 2'h3;
	// ****************************************************************
	// timing: prescaler stage k runs at 16384 / 2^k Hz, so ck[n] sits at bit 15-n
	// ****************************************************************
	localparam int CLK_HZ      = 25_000_000;
	localparam int BASE_HZ     = 32_768;
	localparam int BASE_DIV    = CLK_HZ / BASE_HZ;
	localparam int PRE_W       = 15;
	localparam int TAP_CK12    = 3;
	localparam int TAP_CK11    = 4;
	localparam int TAP_CK10    = 5;
	localparam int TAP_CK8     = 7;
	localparam int TAP_CK6     = 9;
	localparam int TAP_CK4     = 11;
	localparam int TAP_CK1     = 14;
	localparam int TONE3_HZ    = 667;
	localparam int TONE3_HALF  = BASE_HZ / (2 * TONE3_HZ);
endpackage

// *** dv/event_source.sv ***
// event pin source that produces counted bursts of edges
`timescale 1ns/1ns
module event_source (
	input  wire logic clock_i,
	input  wire logic go_i,
	input  wire logic slow_i,
	output logic      event_input_pin_o
);
	// ****************************************************************
	// one rising edge every 16 clocks, or every 256 when slow, while go is high
	// ****************************************************************
	logic [7:0] cnt_reg;
	always_ff @(posedge clock_i) begin
		cnt_reg <= go_i ? cnt_reg + 8'h01 : 8'h00;
	end
	// fast levels stand 8 cycles for the raw path; slow ones stand 128 cycles,
	// long enough to span two debounce ticks at the shortened prescaler; rests low
	assign event_input_pin_o = go_i & (slow_i ? cnt_reg[7] : cnt_reg[3]);
endmodule

// *** dv/tec_props.sv ***
// assertion checker for the timer event counter block
`timescale 1ns/1ns
module tec_props import tec_pkg::*; #(
	parameter int ADDR_W   = 8,
	parameter int BASE_CNT = BASE_DIV
) (
	input wire logic              clock_i,
	input wire logic              sys_rst_i,
	input wire logic              psel_i,
	input wire logic              penable_i,
	input wire logic              pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0]       pwdata_i,
	input wire logic [31:0]       prdata_o,
	input wire logic              pready_o,
	input wire logic              pslverr_o,
	input wire logic              event_input_pin_i,
	input wire logic              tone_output_pin_i,
	input wire logic              tone_output_pin_o,
	input wire logic              tone_output_pin_oe_n_o,
	input wire logic              count_zero_irq_o
);
	// ****************************************************************
	// bus answer, pin ownership and request gating
	// ****************************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	wire logic tone_wr = pready_o && pwrite_i && paddr_i == OFS_TONE_RUN;
	a_ready_after_setup: assert property (
		psel_i && !penable_i |=> pready_o) else $error("no answer after setup");
	a_ready_one_cycle: assert property (
		pready_o |=> !pready_o) else $error("ready longer than one cycle");
	a_err_unmapped: assert property (
		pready_o |-> pslverr_o == (paddr_i > OFS_TONE_PORT || paddr_i[1:0] != 2'h0))
		else $error("error flag wrong for address");
	a_idle_rdata: assert property (
		!pready_o |-> prdata_o == 32'h0) else $error("read data outside access");
	a_tone_owns_pin: assert property (
		tone_wr && pwdata_i[TONE_EN_BIT] |-> ##[1:2] !tone_output_pin_oe_n_o)
		else $error("tone enable did not take the pin");
	a_silence_low: assert property (
		tone_wr && pwdata_i[2:0] == 3'h4 |=> ##2 (!tone_output_pin_o)[*8])
		else $error("silence still toggles");
	a_tone_toggles: assert property (
		tone_wr && pwdata_i[2:0] == 3'h6 |-> ##[1:80] $rose(tone_output_pin_o)
		##[1:40] $fell(tone_output_pin_o)) else $error("tone does not toggle");
	a_mask_gates: assert property (
		pready_o && pwrite_i && paddr_i == OFS_IRQ_MASK && !pwdata_i[0]
		|=> ##1 !count_zero_irq_o) else $error("request despite mask");
endmodule
bind timer_event_counter_buzzer tec_props #(.ADDR_W(ADDR_W), .BASE_CNT(BASE_CNT)) u_props (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .event_input_pin_i(event_input_pin_i),
	.tone_output_pin_i(tone_output_pin_i), .tone_output_pin_o(tone_output_pin_o),
	.tone_output_pin_oe_n_o(tone_output_pin_oe_n_o), .count_zero_irq_o(count_zero_irq_o));

// *** dv/timer_event_counter_buzzer_bench.sv ***
// self-checking bench for the timer event counter block
`timescale 1ns/1ns
module timer_event_counter_buzzer_bench import tec_pkg::*;;
	logic        clock_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0, go = 0, slow = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat, v;
	logic        pready, pslverr, rerr, evt, pin_o, oe_n, irq;
	int          n_fail = 0, total_checks = 0, cyc = 0, k, h;
	initial forever #20 clock_i = ~clock_i;
	timer_event_counter_buzzer #(.BASE_CNT(2)) u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.event_input_pin_i(evt), .tone_output_pin_i(pin_o), .tone_output_pin_o(pin_o),
		.tone_output_pin_oe_n_o(oe_n), .count_zero_irq_o(irq));
	event_source u_src (.clock_i(clock_i), .go_i(go), .slow_i(slow), .event_input_pin_o(evt));
	// ****************************************************************
	// bus tasks and checks
	// ****************************************************************
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	// release costs one idle cycle, so psel is never assigned twice in one step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock_i);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task wait_irq;
		repeat (3) @(posedge clock_i);
		for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge clock_i);
		chk({31'h0, irq}, 32'h1);
	endtask
	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		repeat (10) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
		for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0);
		apb(1'b0, 8'h22, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		$display("test reset done");
		wr(OFS_COUNT_CTRL, 32'h1);
		wr(OFS_TONE_RUN, 32'h8);
		wr(OFS_VALUE_LO, 32'h3);
		repeat (200) @(posedge clock_i);
		rd(OFS_VALUE_LO, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rd(OFS_IRQ_REQ, 32'h4);
		rd(OFS_IRQ_REQ, 32'h0);
		wr(OFS_COUNT_CTRL, 32'h9);
		repeat (40) @(posedge clock_i);
		rd(OFS_VALUE_LO, 32'h0);
		wr(OFS_COUNT_CTRL, 32'h1);
		$display("test one shot done");
		wr(OFS_VALUE_HI, 32'hA);
		wr(OFS_VALUE_LO, 32'h5);
		repeat (60) @(posedge clock_i);
		wr(OFS_TONE_RUN, 32'h0);
		wr(OFS_VALUE_HI, 32'h3);
		apb(1'b0, OFS_VALUE_LO, 32'h0);
		v = rdat;
		rd(OFS_VALUE_HI, 32'hA);
		rd(OFS_VALUE_LO, v);
		$display("test halt done");
		wr(OFS_IRQ_MASK, 32'h1);
		wr(OFS_COUNT_CTRL, 32'h9);
		wr(OFS_VALUE_HI, 32'h0);
		wr(OFS_TONE_RUN, 32'h8);
		wr(OFS_VALUE_LO, 32'h2);
		wait_irq();
		rd(OFS_IRQ_REQ, 32'h4);
		wait_irq();
		wr(OFS_IRQ_MASK, 32'h0);
		wr(OFS_VALUE_LO, 32'h0);
		rd(OFS_COUNT_CTRL, 32'h1);
		rd(OFS_VALUE_LO, 32'h0);
		$display("test reload done");
		wr(OFS_TONE_RUN, 32'h0);
		wr(OFS_EVENT_CFG, 32'h7);
		wr(OFS_VALUE_HI, 32'hF);
		wr(OFS_COUNT_CTRL, 32'h7);
		wr(OFS_VALUE_LO, 32'hF);
		wr(OFS_TONE_RUN, 32'h8);
		go <= 1'b1;
		repeat (80) @(posedge clock_i);
		go <= 1'b0;
		repeat (20) @(posedge clock_i);
		rd(OFS_VALUE_LO, 32'hA);
		rd(OFS_VALUE_HI, 32'hF);
		wr(OFS_TONE_RUN, 32'h0);
		wr(OFS_EVENT_CFG, 32'h3);
		wr(OFS_VALUE_LO, 32'hF);
		wr(OFS_TONE_RUN, 32'h8);
		go <= 1'b1;
		repeat (80) @(posedge clock_i);
		go <= 1'b0;
		repeat (20) @(posedge clock_i);
		rd(OFS_VALUE_LO, 32'hA);
		rd(OFS_VALUE_HI, 32'hF);
		wr(OFS_TONE_RUN, 32'h0);
		wr(OFS_EVENT_CFG, 32'h0);
		wr(OFS_VALUE_LO, 32'hF);
		wr(OFS_TONE_RUN, 32'h8);
		slow <= 1'b1;
		go <= 1'b1;
		repeat (600) @(posedge clock_i);
		go <= 1'b0;
		repeat (200) @(posedge clock_i);
		rd(OFS_VALUE_LO, 32'hD);
		rd(OFS_VALUE_HI, 32'hF);
		$display("test events done");
		wr(OFS_TONE_PORT, 32'h3);
		chk({30'h0, oe_n, pin_o}, 32'h1);
		for (int s = 1; s < 4; s++) begin
			wr(OFS_TONE_RUN, {29'h0, 1'b1, s[1:0]});
			h = 0;
			repeat (200) begin
				@(posedge clock_i);
				h += int'(pin_o === 1'b1);
			end
			chk({31'h0, h > 60 && h < 140}, 32'h1);
			chk({31'h0, oe_n}, 32'h0);
		end
		wr(OFS_TONE_RUN, 32'h4);
		repeat (10) @(posedge clock_i);
		chk({31'h0, pin_o}, 32'h0);
		wr(OFS_TONE_RUN, 32'h0);
		wr(OFS_TONE_PORT, 32'h0);
		chk({31'h0, oe_n}, 32'h1);
		$display("test tone done");
		summarize();
	end
endmodule

// *** src/timer_event_counter_buzzer.sv ***
// timer / event counter with tone output, reached over apb
// Operation
// RULE1: eight-bit down counter clocked by a prescaler tap or event pin edges
// RULE2: reaching zero sets the zero flag; request goes out only when mask is one
// RULE3: source field 0 off, 1..6 taps ck12 ck10 ck8 ck6 ck4 ck1, 7 event pin
// RULE4: after reset the event pin counts on debounced rising edges
// RULE5: auto reload bit clears at reset; writing one enables reloading
// RULE6: run enable bit in tone register runs or halts counting, cleared at reset
// RULE7: writing the low load nibble loads both nibbles and starts counting
// RULE8: high nibble enters the counter only together with a low nibble write; auto reload loads load_hi as last written, even after the last low write
// RULE9: setting auto reload alone starts nothing; it arms at next low write
// RULE10: with auto reload, zero raises the event, reloads and keeps counting
// RULE11: writing zero to the load registers stops counting and clears auto reload
// RULE12: the low value register reads the low nibble of the current count; the high register returns hi_snap, the nibble captured at the last low read
// RULE13: software reads the low nibble before the high nibble
// RULE14: software loads all ones, selects the pin, then sets run enable
// RULE15: tone enable drives the pin with a 50 percent square wave
// RULE16: tone field 00 silent, 01 tap one, 10 tap two, 11 about 667 Hz
// RULE17: writing the tone register changes tone or silence at once
// RULE18: tone enable owns the pin over its direction bit; off gives plain port
// RULE19: control register holds auto reload in bit 3 and source in bits 2..0
// RULE20: mode 0 counts debounced rising edges; mode 1 uses bypass and polarity
// RULE21: reading the main request register clears the zero flag
// RULE22: zero flag sets whatever the mask; mask gates only the request
// RULE23: without auto reload the counter stops at zero until next low write
// RULE24: a low nibble read captures the high nibble for the next high read
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module timer_event_counter_buzzer import tec_pkg::*; #(
	parameter int ADDR_W   = 8,
	parameter int BASE_CNT = BASE_DIV
) (
	input  wire logic              clock_i,
	input  wire logic              sys_rst_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              event_input_pin_i,
	input  wire logic              tone_output_pin_i,
	output logic                   tone_output_pin_o,
	output logic                   tone_output_pin_oe_n_o,
	output logic                   count_zero_irq_o
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [9:0]       div;
		logic [PRE_W-1:0] pre;
		logic [PRE_W-1:0] pre_prev;
		logic [4:0]       t3_cnt;
		logic             t3;
		logic [3:0]       ctrl;
		logic [3:0]       load_lo;
		logic [3:0]       load_hi;
		logic [7:0]       count;
		logic             active;
		logic             armed;
		logic [3:0]       hi_snap;
		logic [3:0]       tone_run;
		logic [3:0]       evcfg;
		logic             flag;
		logic             mask;
		logic [1:0]       port;
		logic             deb_smp;
		logic             deb;
		logic             ev_prev;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic             irq;
		logic             pin_o;
		logic             pin_oe_n;
	} state_s;

	state_s state_reg;
	state_s state_next;

	logic [7:0]  addr;
	logic        setup;
	logic        acc;
	logic        wr;
	logic        rd;
	logic        base_tick;
	logic        ev_level;
	logic        ev_edge;
	logic        deb_tick;
	logic        cnt_tick;
	logic        tone_lvl;
	logic [7:0]  load_val;
	logic [31:0] rdata;
	logic        mapped;

	function automatic logic rise(input logic [PRE_W-1:0] now, input logic [PRE_W-1:0] prev,
		input int k);
		return now[k] & ~prev[k];
	endfunction

	assign addr  = 8'(paddr_i);
	assign setup = psel_i & ~penable_i;
	assign acc   = psel_i & penable_i & state_reg.pready;
	assign wr    = acc & pwrite_i;
	assign rd    = acc & ~pwrite_i;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		load_val   = 8'h00;
		// ************************************************************
		// prescaler: base tick near 32768 Hz, stage counter gives taps
		// ************************************************************
		base_tick = (state_reg.div == 10'(BASE_CNT - 1));
		state_next.div = base_tick ? 10'h000 : state_reg.div + 10'h001;
		if (base_tick) begin
			state_next.pre = state_reg.pre + 15'h0001;
		end
		state_next.pre_prev = state_reg.pre;
		// third tone: its own half-period counter, since no tap lands near 667 Hz
		if (base_tick) begin
			if (state_reg.t3_cnt == 5'(TONE3_HALF - 1)) begin
				state_next.t3_cnt = 5'h00;
				state_next.t3     = ~state_reg.t3;
			end else begin
				state_next.t3_cnt = state_reg.t3_cnt + 5'h01;
			end
		end
		// ************************************************************
		// event pin: debounce needs the level equal on two tap edges
		// ************************************************************
		deb_tick = state_reg.evcfg[EVT_DEBLONG_BIT] ?
			rise(state_reg.pre, state_reg.pre_prev, TAP_CK8) :
			rise(state_reg.pre, state_reg.pre_prev, TAP_CK11);
		if (deb_tick) begin
			state_next.deb_smp = event_input_pin_i;
			if (state_reg.deb_smp == event_input_pin_i) begin
				state_next.deb = event_input_pin_i;
			end
		end
		if (!state_reg.evcfg[EVT_MODE_BIT]) begin
			ev_level = state_reg.deb; // RULE4
		end else if (state_reg.evcfg[EVT_BYPASS_BIT]) begin
			ev_level = event_input_pin_i; // RULE20
		end else begin
			ev_level = state_reg.deb; // RULE20
		end
		state_next.ev_prev = ev_level;
		if (!state_reg.evcfg[EVT_MODE_BIT] || state_reg.evcfg[EVT_RISING_BIT]) begin
			ev_edge = ev_level & ~state_reg.ev_prev; // RULE20
		end else begin
			ev_edge = ~ev_level & state_reg.ev_prev; // RULE20
		end
		// ************************************************************
		// counter clock source
		// ************************************************************
		case (state_reg.ctrl[2:0]) // RULE3
			3'h1:    cnt_tick = rise(state_reg.pre, state_reg.pre_prev, TAP_CK12);
			3'h2:    cnt_tick = rise(state_reg.pre, state_reg.pre_prev, TAP_CK10);
			3'h3:    cnt_tick = rise(state_reg.pre, state_reg.pre_prev, TAP_CK8);
			3'h4:    cnt_tick = rise(state_reg.pre, state_reg.pre_prev, TAP_CK6);
			3'h5:    cnt_tick = rise(state_reg.pre, state_reg.pre_prev, TAP_CK4);
			3'h6:    cnt_tick = rise(state_reg.pre, state_reg.pre_prev, TAP_CK1);
			SRC_EVENT: cnt_tick = ev_edge; // RULE1
			default: cnt_tick = 1'b0;
		endcase
		// ************************************************************
		// down counter
		// ************************************************************
		if (cnt_tick && state_reg.active && state_reg.tone_run[RUN_EN_BIT]) begin // RULE6
			state_next.count = state_reg.count - 8'h01; // RULE1
			if (state_reg.count == 8'h01) begin
				state_next.flag = 1'b1; // RULE2 RULE22
				if (state_reg.armed && state_reg.ctrl[CTRL_AUTO_BIT]) begin
					state_next.count = {state_reg.load_hi, state_reg.load_lo}; // RULE10
				end else begin
					state_next.active = 1'b0; // RULE23
				end
			end
		end
		// ************************************************************
		// apb slave: zero wait, answer prepared in the setup cycle
		// ************************************************************
		mapped = 1'b1;
		case (addr)
			OFS_COUNT_CTRL: rdata = {28'h0000000, state_reg.ctrl};
			OFS_VALUE_LO:   rdata = {28'h0000000, state_reg.count[3:0]}; // RULE12
			OFS_VALUE_HI:   rdata = {28'h0000000, state_reg.hi_snap}; // RULE24
			OFS_TONE_RUN:   rdata = {28'h0000000, state_reg.tone_run};
			OFS_EVENT_CFG:  rdata = {28'h0000000, state_reg.evcfg};
			OFS_IRQ_REQ:    rdata = {29'h00000000, state_reg.flag, 2'h0};
			OFS_IRQ_MASK:   rdata = {31'h00000000, state_reg.mask};
			OFS_TONE_PORT:  rdata = {30'h00000000, state_reg.port};
			default: begin
				rdata  = 32'h00000000;
				mapped = 1'b0;
			end
		endcase
		state_next.pready = setup;
		if (setup) begin
			state_next.prdata  = pwrite_i ? 32'h00000000 : rdata;
			state_next.pslverr = ~mapped;
		end else begin
			state_next.prdata  = 32'h00000000;
			state_next.pslverr = 1'b0;
		end
		if (rd && addr == OFS_VALUE_LO) begin
			state_next.hi_snap = state_reg.count[7:4]; // RULE24
		end
		if (rd && addr == OFS_IRQ_REQ) begin
			state_next.flag = 1'b0; // RULE21
			if (cnt_tick && state_reg.active && state_reg.tone_run[RUN_EN_BIT] &&
				state_reg.count == 8'h01) begin
				state_next.flag = 1'b1; // RULE22
			end
		end
		if (wr) begin
			case (addr)
				OFS_COUNT_CTRL: begin
					state_next.ctrl = pwdata_i[3:0]; // RULE19 RULE5
					if (!pwdata_i[CTRL_AUTO_BIT]) begin
						state_next.armed = 1'b0; // RULE9
					end
				end
				OFS_VALUE_HI: state_next.load_hi = pwdata_i[3:0]; // RULE8
				OFS_VALUE_LO: begin
					load_val = {state_reg.load_hi, pwdata_i[3:0]};
					state_next.load_lo = pwdata_i[3:0];
					if (load_val == 8'h00) begin
						state_next.count  = 8'h00; // RULE11
						state_next.active = 1'b0; // RULE11
						state_next.armed  = 1'b0;
						state_next.ctrl[CTRL_AUTO_BIT] = 1'b0; // RULE11
					end else begin
						state_next.count  = load_val; // RULE7 RULE8
						state_next.active = 1'b1; // RULE7
						state_next.armed  = state_reg.ctrl[CTRL_AUTO_BIT]; // RULE9
					end
				end
				OFS_TONE_RUN:  state_next.tone_run = pwdata_i[3:0]; // RULE6 RULE17
				OFS_EVENT_CFG: state_next.evcfg = pwdata_i[3:0];
				OFS_IRQ_MASK:  state_next.mask = pwdata_i[0];
				OFS_TONE_PORT: state_next.port = pwdata_i[1:0];
				default: ;
			endcase
		end
		state_next.irq = state_next.flag & state_next.mask; // RULE2 RULE22
		// ************************************************************
		// tone pin: output follows the register written this cycle
		// ************************************************************
		case (state_next.tone_run[1:0]) // RULE16
			TONE_ONE:   tone_lvl = state_next.pre[TAP_CK11]; // RULE15
			TONE_TWO:   tone_lvl = state_next.pre[TAP_CK12]; // RULE15
			TONE_THREE: tone_lvl = state_next.t3; // RULE15
			default:    tone_lvl = 1'b0;
		endcase
		if (state_next.tone_run[TONE_EN_BIT]) begin
			state_next.pin_o    = tone_lvl; // RULE17 RULE18
			state_next.pin_oe_n = 1'b0; // RULE18
		end else begin
			state_next.pin_o    = state_next.port[PORT_DATA_BIT]; // RULE18
			state_next.pin_oe_n = ~state_next.port[PORT_DIR_BIT]; // RULE18
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_reg          <= '0;
			state_reg.pin_oe_n <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata_o               = state_reg.prdata;
	assign pready_o               = state_reg.pready;
	assign pslverr_o              = state_reg.pslverr;
	assign tone_output_pin_o      = state_reg.pin_o;
	assign tone_output_pin_oe_n_o = state_reg.pin_oe_n;
	assign count_zero_irq_o       = state_reg.irq;
endmodule
